//--- rtl/sfd_pkg.sv
// Purpose: shared constants, types and command codes of the supply fault detector bank
// Assumes: 10 MHz system clock; per-channel commands are selected by a page number
// Notes:   the struct layouts below are the bit layouts seen on the command port
package sfd_pkg;

  // ****************************************************************
  // channel counts and widths
  // ****************************************************************
  localparam int NCH    = 17;  // all fault detector channels
  localparam int NHIGH  = 4;   // high range inputs come first
  localparam int NLOW   = 13;  // low range inputs follow
  localparam int CODE_W = 12;  // converter code width
  localparam int DATA_W = 16;  // command data width
  localparam int PAGE_W = 5;
  localparam int FILT_W = 7;

  // ****************************************************************
  // command codes
  // ****************************************************************
  localparam logic [7:0] CMD_EXPONENT  = 8'h20;
  localparam logic [7:0] CMD_TRIM      = 8'h22;
  localparam logic [7:0] CMD_SCALE     = 8'h2A;
  localparam logic [7:0] CMD_OV_FAULT  = 8'h40;
  localparam logic [7:0] CMD_OV_WARN   = 8'h42;
  localparam logic [7:0] CMD_UV_WARN   = 8'h43;
  localparam logic [7:0] CMD_UV_FAULT  = 8'h44;
  localparam logic [7:0] CMD_READBACK  = 8'h8B;
  localparam logic [7:0] CMD_OV_HYST   = 8'hD0;
  localparam logic [7:0] CMD_UV_HYST   = 8'hD1;
  localparam logic [7:0] CMD_CHAN_CFG  = 8'hD8;
  localparam logic [7:0] CMD_BOOT_STAT = 8'hD9;

  // ****************************************************************
  // reset values and masks
  // ****************************************************************
  localparam logic [7:0]  EXP_RST    = 8'h00;
  localparam logic [15:0] TRIM_RST   = 16'h0000;
  localparam logic [15:0] SCALE_RST  = 16'h1000;  // unity divider ratio
  localparam logic [15:0] LIMIT_RST  = 16'h0000;
  localparam logic [15:0] CFG_RST    = 16'h0200;  // detectors off, 2 us filter
  localparam logic [15:0] CFG_WMASK  = 16'h7F77;  // reserved bits stay zero
  localparam int          SCALE_FRAC = 12;        // scale is unsigned 4.12

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_NS       = 1000;                      // filter clock, 1 us
  localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
  localparam int FILT_MIN_US   = 2;
  localparam int FILT_MAX_US   = 100;
  localparam int RR_MS         = 5;                         // full round robin
  localparam int RR_CYC_PER_CH = (RR_MS * 1000000) / (CLK_PERIOD_NS * NCH);

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [2:0] {
    RANGE_0V4  = 3'b000,
    RANGE_0V75 = 3'b001,
    RANGE_1V5  = 3'b010,
    RANGE_2V0  = 3'b011,  // low range inputs only
    RANGE_3V0  = 3'b100,  // high range inputs only
    RANGE_6V0  = 3'b101   // high range inputs only
  } range_e;

  typedef enum logic [2:0] {
    BOOT_CHECK  = 3'b000,
    BOOT_REPORT = 3'b001,
    BOOT_SELECT = 3'b010,
    BOOT_RUN    = 3'b011,
    BOOT_FAIL   = 3'b100
  } boot_state_e;

  typedef struct packed {
    logic              rsvd_hi;
    logic [FILT_W-1:0] filt_us;
    logic              rsvd_mid;
    range_e            range_sel;
    logic              rsvd_lo;
    logic              diff_en;
    logic              uv_en;
    logic              ov_en;
  } chan_cfg_s;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [PAGE_W-1:0] page;
    logic [7:0]        code;
    logic [DATA_W-1:0] data;
  } cmd_s;

endpackage

//--- rtl/supply_fault_detector_bank.sv
// Purpose: seventeen supply fault detector channels with hysteresis, glitch filters,
//          round robin warnings, readback and boot-time integrity check
// Assumes: in_code_i carries the attenuated input levels from the analog front end,
//          asynchronous to clk_i; command, check and selection ports are on clk_i
// Notes:   fault flags go only to the sequencing engine port, warnings only to the
//          logic block port
//
// Summary of operation
// - seventeen channels: four high, thirteen low range
// - odd/even low pairs; last low input never paired
// - odd channel of pair evaluates the difference
// - each channel flags undervoltage and/or overvoltage
// - threshold range legal only for its input kind
// - undervoltage clears above limit plus hysteresis
// - overvoltage clears below limit minus hysteresis
// - glitch filter per comparator, 2 to 100 us
// - warnings compare readings against warning limits
// - round robin visits every channel within 5 ms
// - warnings reach only the logic block
// - one exponent applies to all limit mantissas
// - fault limit mantissas at 0x40 and 0x44
// - hysteresis mantissas at 0xD0 and 0xD1
// - readback returns selected channel conversion
// - readback stays valid above supervisory range
// - offset trim added to thresholds and readback
// - per-channel divider ratio scales readback and comparisons
// - check four memory sections before running
// - report results; master selects the configuration
// - fault comparators evaluate continuously, not sampled
`timescale 1ns/1ps
`default_nettype none

module supply_fault_detector_bank
  import sfd_pkg::*;
#(
  parameter int RR_CYC = RR_CYC_PER_CH
)(
  // clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rstn_i,
  // input levels from the attenuators
  input  wire logic [NCH-1:0][CODE_W-1:0] in_code_i,
  // command port
  input  wire cmd_s                   cmd_i,
  output logic [DATA_W-1:0]           rdata_o,
  output logic                        rvalid_o,
  output logic                        cmd_err_o,
  // memory integrity checker
  output logic                        chk_req_o,
  output logic [1:0]                  chk_section_o,
  input  wire logic                   chk_done_i,
  input  wire logic                   chk_pass_i,
  // inter_device_bus configuration agreement
  input  wire logic                   standalone_i,
  output logic                        idb_report_valid_o,
  output logic [1:0]                  idb_report_o,
  input  wire logic                   idb_sel_valid_i,
  input  wire logic                   idb_sel_backup_i,
  output logic                        ready_o,
  output logic                        cfg_backup_o,
  // sequencing_engine faults
  output logic [NCH-1:0]              se_ov_fault_o,
  output logic [NCH-1:0]              se_uv_fault_o,
  // logic block warnings
  output logic [NCH-1:0]              lb_ov_warn_o,
  output logic [NCH-1:0]              lb_uv_warn_o
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  if (RR_CYC < 1 || RR_CYC * NCH > RR_MS * 1000000 / CLK_PERIOD_NS)
  begin : g_rr_check
    $error("round robin slot does not fit the sweep time");
  end
  if (NCH != NHIGH + NLOW)
  begin : g_ch_check
    $error("channel counts do not add up");
  end

  // ****************************************************************
  // functions
  // ****************************************************************
  // divider ratio and exponent applied to a converter code
  function automatic logic [15:0] scale_code(input logic [CODE_W-1:0] code,
                                             input logic [15:0] scale,
                                             input logic [7:0] expo);
    logic [27:0] prod;
    logic [15:0] s;
    prod = 28'(code) * 28'(scale);
    s    = prod[SCALE_FRAC+15:SCALE_FRAC];
    return s >> expo[3:0];
  endfunction

  // signed offset trim with saturation
  function automatic logic [15:0] add_trim(input logic [15:0] v, input logic [15:0] trim);
    logic signed [17:0] sum;
    sum = $signed({2'b00, v}) + $signed({{2{trim[15]}}, trim});
    if (sum < 0)
      return 16'h0000;
    else if (sum > 18'sh0FFFF)
      return 16'hFFFF;
    else
      return sum[15:0];
  endfunction

  function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[16] ? 16'hFFFF : s[15:0];
  endfunction

  function automatic logic [15:0] sat_sub(input logic [15:0] a, input logic [15:0] b);
    return (a > b) ? a - b : 16'h0000;
  endfunction

  // legal threshold range for the kind of input
  function automatic logic range_ok(input logic high, input range_e r);
    if (high)
      return (r == RANGE_0V4) || (r == RANGE_0V75) || (r == RANGE_1V5) ||
             (r == RANGE_3V0) || (r == RANGE_6V0);
    else
      return (r == RANGE_0V4) || (r == RANGE_0V75) || (r == RANGE_1V5) ||
             (r == RANGE_2V0);
  endfunction

  // filter time held inside its programmable span
  function automatic logic [FILT_W-1:0] filt_clamp(input logic [FILT_W-1:0] f);
    if (f < FILT_W'(FILT_MIN_US))
      return FILT_W'(FILT_MIN_US);
    else if (f > FILT_W'(FILT_MAX_US))
      return FILT_W'(FILT_MAX_US);
    else
      return f;
  endfunction

  // ****************************************************************
  // storage
  // ****************************************************************
  logic [NCH-1:0][CODE_W-1:0] sync1_r;
  logic [NCH-1:0][CODE_W-1:0] sync2_r;
  logic [7:0]                 expo_r;
  logic [15:0]                trim_r;
  logic [15:0]                scale_r   [NCH];
  logic [15:0]                ovf_r     [NCH];
  logic [15:0]                uvf_r     [NCH];
  logic [15:0]                ovw_r     [NCH];
  logic [15:0]                uvw_r     [NCH];
  logic [15:0]                ovh_r     [NCH];
  logic [15:0]                uvh_r     [NCH];
  chan_cfg_s                  cfg_r     [NCH];
  logic [15:0]                rdback_r  [NCH];
  logic [2*NCH-1:0]           flt_r;
  logic [FILT_W-1:0]          fcnt_r    [2*NCH];
  logic [3:0]                 tick_cnt_r;
  logic [11:0]                rr_cnt_r;
  logic [PAGE_W-1:0]          rr_ch_r;
  boot_state_e                boot_r;
  logic [1:0]                 sect_r;
  logic                       main_ok_r;
  logic                       backup_ok_r;

  // ****************************************************************
  // input synchroniser
  // ****************************************************************
  // two flops per level; the converter holds its code between updates
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
    end
    else
    begin
      sync1_r <= in_code_i;
      sync2_r <= sync1_r;
    end
  end

  // ****************************************************************
  // channel values
  // ****************************************************************
  logic [CODE_W-1:0] volt_code [NCH];
  logic [15:0]       chan_val  [NCH];
  logic [2*NCH-1:0]  cmp_raw;
  logic [NCH-1:0]    chan_live;

  // difference for the odd member of an enabled pair, else single ended
  always_comb
  begin
    for (int ch = 0; ch < NCH; ch++)
    begin
      volt_code[ch] = sync2_r[ch];
      // both members share one range, software keeps them equal
      if (ch >= NHIGH && ch < NCH - 1 && ((ch - NHIGH) % 2) == 0 && cfg_r[ch].diff_en)
      begin
        volt_code[ch] = (sync2_r[ch] > sync2_r[ch+1]) ? sync2_r[ch] - sync2_r[ch+1]
                                                     : '0;
      end
      chan_val[ch]  = scale_code(volt_code[ch], scale_r[ch], expo_r);
      chan_live[ch] = range_ok(ch < NHIGH, cfg_r[ch].range_sel);
    end
  end

  // comparators with hysteresis, evaluated every cycle
  always_comb
  begin
    for (int ch = 0; ch < NCH; ch++)
    begin
      logic [15:0] ov_lim;
      logic [15:0] uv_lim;
      ov_lim = add_trim(ovf_r[ch], trim_r);
      uv_lim = add_trim(uvf_r[ch], trim_r);
      if (flt_r[ch])
        cmp_raw[ch] = chan_val[ch] > sat_sub(ov_lim, ovh_r[ch]);
      else
        cmp_raw[ch] = chan_val[ch] > ov_lim;
      if (flt_r[NCH+ch])
        cmp_raw[NCH+ch] = chan_val[ch] < sat_add(uv_lim, uvh_r[ch]);
      else
        cmp_raw[NCH+ch] = chan_val[ch] < uv_lim;
      cmp_raw[ch]     = cmp_raw[ch] & cfg_r[ch].ov_en & chan_live[ch];
      cmp_raw[NCH+ch] = cmp_raw[NCH+ch] & cfg_r[ch].uv_en & chan_live[ch];
    end
  end

  // ****************************************************************
  // glitch filters
  // ****************************************************************
  wire tick = (tick_cnt_r == 4'(TICK_CYC - 1));

  // 1 us filter clock
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      tick_cnt_r <= '0;
    else
      tick_cnt_r <= tick ? '0 : tick_cnt_r + 4'h1;
  end

  // fault only after the comparator holds longer than the filter time
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      flt_r <= '0;
      for (int j = 0; j < 2*NCH; j++)
        fcnt_r[j] <= '0;
    end
    else if (tick)
    begin
      for (int j = 0; j < 2*NCH; j++)
      begin
        if (!cmp_raw[j])
        begin
          fcnt_r[j] <= '0;
          flt_r[j]  <= 1'b0;
        end
        else if (fcnt_r[j] > filt_clamp(cfg_r[j % NCH].filt_us))
          flt_r[j] <= 1'b1;
        else
          fcnt_r[j] <= fcnt_r[j] + 7'h01;
      end
    end
  end

  // ****************************************************************
  // converter round robin, warnings and readback
  // ****************************************************************
  wire rr_last = (rr_cnt_r == 12'(RR_CYC - 1));
  wire [15:0] rr_val = chan_val[rr_ch_r];

  // one slot per channel, all seventeen inside the sweep time
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rr_cnt_r     <= '0;
      rr_ch_r      <= '0;
      lb_ov_warn_o <= '0;
      lb_uv_warn_o <= '0;
      for (int ch = 0; ch < NCH; ch++)
        rdback_r[ch] <= '0;
    end
    else
    begin
      rr_cnt_r <= rr_last ? '0 : rr_cnt_r + 12'h001;
      if (rr_last)
      begin
        rr_ch_r <= (rr_ch_r == PAGE_W'(NCH - 1)) ? '0 : rr_ch_r + 5'h01;
        rdback_r[rr_ch_r] <= add_trim(rr_val, trim_r);
        lb_ov_warn_o[rr_ch_r] <= cfg_r[rr_ch_r].ov_en &
                                 (rr_val > add_trim(ovw_r[rr_ch_r], trim_r));
        lb_uv_warn_o[rr_ch_r] <= cfg_r[rr_ch_r].uv_en &
                                 (rr_val < add_trim(uvw_r[rr_ch_r], trim_r));
      end
    end
  end

  // ****************************************************************
  // fault outputs
  // ****************************************************************
  wire running = (boot_r == BOOT_RUN);

  // filtered faults go to the sequencing engine once the device runs
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      se_ov_fault_o <= '0;
      se_uv_fault_o <= '0;
    end
    else
    begin
      se_ov_fault_o <= flt_r[NCH-1:0] & {NCH{running}};
      se_uv_fault_o <= flt_r[2*NCH-1:NCH] & {NCH{running}};
    end
  end

  // ****************************************************************
  // command decode
  // ****************************************************************
  wire        page_ok  = (cmd_i.page < PAGE_W'(NCH));
  wire        code_glb = (cmd_i.code == CMD_EXPONENT) || (cmd_i.code == CMD_TRIM) ||
                         (cmd_i.code == CMD_BOOT_STAT);
  wire        code_pg  = (cmd_i.code == CMD_SCALE) || (cmd_i.code == CMD_OV_FAULT) ||
                         (cmd_i.code == CMD_UV_FAULT) || (cmd_i.code == CMD_OV_WARN) ||
                         (cmd_i.code == CMD_UV_WARN) || (cmd_i.code == CMD_OV_HYST) ||
                         (cmd_i.code == CMD_UV_HYST) || (cmd_i.code == CMD_CHAN_CFG) ||
                         (cmd_i.code == CMD_READBACK);
  wire        code_ro  = (cmd_i.code == CMD_READBACK) || (cmd_i.code == CMD_BOOT_STAT);
  wire        cmd_ok   = code_glb || (code_pg && page_ok);
  wire        wr_ok    = cmd_i.wr && cmd_ok && !code_ro;
  wire [PAGE_W-1:0] pg = page_ok ? cmd_i.page : '0;
  wire [15:0] boot_stat = {9'h000, boot_r, sect_r, main_ok_r, backup_ok_r};
  logic [15:0] rd_mux;

  // read data selection
  always_comb
  begin
    if (cmd_i.code == CMD_EXPONENT)
      rd_mux = {8'h00, expo_r};
    else if (cmd_i.code == CMD_TRIM)
      rd_mux = trim_r;
    else if (cmd_i.code == CMD_BOOT_STAT)
      rd_mux = boot_stat;
    else if (cmd_i.code == CMD_SCALE)
      rd_mux = scale_r[pg];
    else if (cmd_i.code == CMD_OV_FAULT)
      rd_mux = ovf_r[pg];
    else if (cmd_i.code == CMD_UV_FAULT)
      rd_mux = uvf_r[pg];
    else if (cmd_i.code == CMD_OV_WARN)
      rd_mux = ovw_r[pg];
    else if (cmd_i.code == CMD_UV_WARN)
      rd_mux = uvw_r[pg];
    else if (cmd_i.code == CMD_OV_HYST)
      rd_mux = ovh_r[pg];
    else if (cmd_i.code == CMD_UV_HYST)
      rd_mux = uvh_r[pg];
    else if (cmd_i.code == CMD_CHAN_CFG)
      rd_mux = cfg_r[pg];
    else if (cmd_i.code == CMD_READBACK)
      rd_mux = rdback_r[pg];
    else
      rd_mux = 16'h0000;
  end

  // global settings and read answer
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      expo_r    <= EXP_RST;
      trim_r    <= TRIM_RST;
      rdata_o   <= '0;
      rvalid_o  <= 1'b0;
      cmd_err_o <= 1'b0;
    end
    else
    begin
      if (wr_ok && cmd_i.code == CMD_EXPONENT)
        expo_r <= cmd_i.data[7:0];
      if (wr_ok && cmd_i.code == CMD_TRIM)
        trim_r <= cmd_i.data;
      rvalid_o  <= cmd_i.rd && cmd_ok;
      rdata_o   <= (cmd_i.rd && cmd_ok) ? rd_mux : 16'h0000;
      cmd_err_o <= ((cmd_i.rd || cmd_i.wr) && !cmd_ok) || (cmd_i.wr && cmd_ok && code_ro);
    end
  end

  // per-channel settings
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      for (int ch = 0; ch < NCH; ch++)
      begin
        scale_r[ch] <= SCALE_RST;
        ovf_r[ch]   <= LIMIT_RST;
        uvf_r[ch]   <= LIMIT_RST;
        ovw_r[ch]   <= LIMIT_RST;
        uvw_r[ch]   <= LIMIT_RST;
        ovh_r[ch]   <= LIMIT_RST;
        uvh_r[ch]   <= LIMIT_RST;
        cfg_r[ch]   <= CFG_RST;
      end
    end
    else if (wr_ok)
    begin
      if (cmd_i.code == CMD_SCALE)
        scale_r[pg] <= cmd_i.data;
      if (cmd_i.code == CMD_OV_FAULT)
        ovf_r[pg] <= cmd_i.data;
      if (cmd_i.code == CMD_UV_FAULT)
        uvf_r[pg] <= cmd_i.data;
      if (cmd_i.code == CMD_OV_WARN)
        ovw_r[pg] <= cmd_i.data;
      if (cmd_i.code == CMD_UV_WARN)
        uvw_r[pg] <= cmd_i.data;
      if (cmd_i.code == CMD_OV_HYST)
        ovh_r[pg] <= cmd_i.data;
      if (cmd_i.code == CMD_UV_HYST)
        uvh_r[pg] <= cmd_i.data;
      if (cmd_i.code == CMD_CHAN_CFG)
        cfg_r[pg] <= cmd_i.data & CFG_WMASK;
    end
  end

  // ****************************************************************
  // boot integrity check and configuration agreement
  // ****************************************************************
  // sections: 0 boot loader, 1 firmware, 2 main config, 3 backup config
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      boot_r             <= BOOT_CHECK;
      sect_r             <= '0;
      main_ok_r          <= 1'b0;
      backup_ok_r        <= 1'b0;
      chk_req_o          <= 1'b0;
      chk_section_o      <= '0;
      idb_report_valid_o <= 1'b0;
      idb_report_o       <= '0;
      ready_o            <= 1'b0;
      cfg_backup_o       <= 1'b0;
    end
    else
    begin
      case (boot_r)
        BOOT_CHECK:
        begin
          chk_req_o     <= !chk_done_i;
          chk_section_o <= sect_r;
          if (chk_done_i)
          begin
            if (sect_r == 2'd2)
              main_ok_r <= chk_pass_i;
            if (sect_r == 2'd3)
              backup_ok_r <= chk_pass_i;
            if (sect_r < 2'd2 && !chk_pass_i)
              boot_r <= BOOT_FAIL;
            else if (sect_r == 2'd3)
              boot_r <= BOOT_REPORT;
            else
              sect_r <= sect_r + 2'd1;
          end
        end
        BOOT_REPORT:
        begin
          idb_report_valid_o <= 1'b1;
          idb_report_o       <= {main_ok_r, backup_ok_r};
          boot_r             <= BOOT_SELECT;
        end
        BOOT_SELECT:
        begin
          if (standalone_i)
          begin
            cfg_backup_o <= !main_ok_r && backup_ok_r;
            boot_r       <= (main_ok_r || backup_ok_r) ? BOOT_RUN : BOOT_FAIL;
          end
          else if (idb_sel_valid_i)
          begin
            cfg_backup_o <= idb_sel_backup_i;
            boot_r       <= BOOT_RUN;
          end
        end
        BOOT_RUN:
        begin
          ready_o <= 1'b1;
        end
        BOOT_FAIL:
        begin
          chk_req_o <= 1'b0;
          ready_o   <= 1'b0;
        end
        default:
        begin
          boot_r <= BOOT_FAIL;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

//--- verification/sfd_bank_chk.sv
// Purpose: port assertions of the fault detector bank
// Assumes: one clock domain, reset async active low
// Notes:   attached to every bank by the bind below
`timescale 1ns/1ps
`default_nettype none
module sfd_bank_chk
  import sfd_pkg::*;
(
  // watched ports
  input wire logic              clk_i,
  input wire logic              rstn_i,
  input wire cmd_s              cmd_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic              rvalid_o,
  input wire logic              cmd_err_o,
  input wire logic              chk_req_o,
  input wire logic              ready_o,
  input wire logic              idb_report_valid_o,
  input wire logic [NCH-1:0]    se_ov_fault_o
);
  // ****
  // command answers and boot order
  // ****
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  chk_rd_answer: assert property (
    cmd_i.rd && cmd_i.code == CMD_OV_FAULT && cmd_i.page < 17 |=> rvalid_o)
    else $error("read lost");
  chk_page_refuse: assert property (
    (cmd_i.rd || cmd_i.wr) && cmd_i.code == CMD_UV_FAULT && cmd_i.page >= 17 |=> cmd_err_o)
    else $error("bad page taken");
  chk_ro_refuse: assert property (
    cmd_i.wr && cmd_i.code == CMD_READBACK |=> cmd_err_o) else $error("ro write taken");
  chk_code_refuse: assert property (
    cmd_i.rd && cmd_i.code == 8'h41 |=> cmd_err_o && !rvalid_o) else $error("bad code taken");
  chk_rdata_idle: assert property (
    !rvalid_o |-> rdata_o == '0) else $error("stray read data");
  chk_faults_gated: assert property (
    !ready_o |-> se_ov_fault_o == '0) else $error("fault before run");
  chk_run_hold: assert property (
    ready_o |-> !chk_req_o ##1 ready_o) else $error("run not held");
  chk_report_first: assert property (
    $rose(ready_o) |-> idb_report_valid_o) else $error("run before report");
endmodule
bind supply_fault_detector_bank sfd_bank_chk sfd_bank_chk_inst (
  .clk_i(clk_i), .rstn_i(rstn_i), .cmd_i(cmd_i), .rdata_o(rdata_o),
  .rvalid_o(rvalid_o), .cmd_err_o(cmd_err_o), .chk_req_o(chk_req_o), .ready_o(ready_o),
  .idb_report_valid_o(idb_report_valid_o), .se_ov_fault_o(se_ov_fault_o));
`default_nettype wire

//--- verification/sfd_mem_model.sv
// Purpose: memory integrity checker beside the bank
// Assumes: each section request is answered after a few cycles
// Notes:   the result line wanders while no answer is given
`timescale 1ns/1ps
`default_nettype none
module sfd_mem_model (
  // request side
  input  wire logic       clk_i,
  input  wire logic       req_i,
  input  wire logic [1:0] sec_i,
  input  wire logic [3:0] bad_i,
  // answer side
  output logic            done_o = 1'b0,
  output logic            pass_o = 1'b0
);
  // ****
  // section check
  // ****
  int wait_r = 0;
  // one done pulse per request; pass means something only with it
  always @(posedge clk_i)
  begin
    wait_r <= (req_i && !done_o) ? wait_r + 1 : 0;
    done_o <= req_i && !done_o && wait_r == 3;
    pass_o <= (req_i && !done_o && wait_r == 3) ? !bad_i[sec_i] : !pass_o;
  end
endmodule
`default_nettype wire

//--- verification/test_supply_fault_detector_bank.sv
// Purpose: self-checking bench of the fault detector bank
// Assumes: 10 MHz clock, round robin slot shortened to 4 cycles
// Notes:   a register model checks the nine written registers; the readback read is checked against a fixed value
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin errors++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
`define WT(c, n) for (i = 0; (c) !== 1'b1; i++) begin \
  if (i == n) begin errors++; tally_and_finish; end @(posedge clk_i) #1; end
module test_supply_fault_detector_bank import sfd_pkg::*;;
  // ****
  // stimulus, register model and checks
  // ****
  logic                       clk_i = 1'b0, rstn_i = 1'b0, sel_v = 1'b0, done, pass;
  logic [NCH-1:0][CODE_W-1:0] in_code_i = '0;
  cmd_s                       cmd_i = '0;
  logic [DATA_W-1:0]          rdata_o, d, mdl [int];
  logic                       rvalid_o, cmd_err_o, chk_req_o, ready_o, idb_report_valid_o;
  logic                       cfg_backup_o;
  logic [1:0]                 sec, idb_report_o;
  logic [NCH-1:0]             se_ov_fault_o, lb_ov_warn_o;
  logic [4:0]                 pg;
  logic [7:0]                 codes [9] = '{CMD_EXPONENT, CMD_TRIM, CMD_SCALE, CMD_OV_FAULT,
                                            CMD_OV_WARN, CMD_UV_WARN, CMD_UV_FAULT, CMD_OV_HYST,
                                            CMD_UV_HYST};
  int                         errors = 0, checks = 0, seed = 52, i, k;
  supply_fault_detector_bank #(.RR_CYC(4)) supply_fault_detector_bank_inst (
    .clk_i(clk_i), .rstn_i(rstn_i), .in_code_i(in_code_i), .cmd_i(cmd_i),
    .rdata_o(rdata_o), .rvalid_o(rvalid_o), .cmd_err_o(cmd_err_o), .chk_req_o(chk_req_o),
    .chk_section_o(sec), .chk_done_i(done), .chk_pass_i(pass), .standalone_i(1'b0),
    .idb_report_valid_o(idb_report_valid_o), .idb_report_o(idb_report_o),
    .idb_sel_valid_i(sel_v), .idb_sel_backup_i(1'b1), .ready_o(ready_o),
    .cfg_backup_o(cfg_backup_o), .se_ov_fault_o(se_ov_fault_o), .se_uv_fault_o(),
    .lb_ov_warn_o(lb_ov_warn_o), .lb_uv_warn_o());
  sfd_mem_model sfd_mem_model_inst (.clk_i(clk_i), .req_i(chk_req_o), .sec_i(sec),
    .bad_i(4'b0100), .done_o(done), .pass_o(pass));
  // clock, 100 ns period
  always #50 clk_i = ~clk_i;
  // one command cycle; its answer stands when this returns
  task automatic op(input logic w, r, input logic [4:0] p, input logic [7:0] c,
                    input logic [15:0] v);
    @(posedge clk_i) #1 cmd_i = '{w, r, p, c, v};
    @(posedge clk_i) #1 cmd_i = '0;
  endtask
  // counts and verdict
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge clk_i);
    #1 rstn_i = 1'b1;
    `WT(idb_report_valid_o, 400)
    `CHK("report", 2'b01, idb_report_o)
    @(posedge clk_i) #1 sel_v = 1'b1;
    `WT(ready_o, 20)
    `CHK("backup", 1'b1, cfg_backup_o)
    $display("boot test done");
    for (k = 0; k < 9; k++)
    begin
      pg = 5'($unsigned($random(seed)) % 16 + 1);
      d = 16'($random(seed));
      op(1'b1, 1'b0, pg, codes[k], d);
      mdl[{pg, codes[k]}] = (codes[k] == CMD_EXPONENT) ? {8'h00, d[7:0]} : d;
      op(1'b0, 1'b1, pg, codes[k], '0);
      `CHK("reg", mdl[{pg, codes[k]}], rdata_o)
    end
    op(1'b1, 1'b0, 5'h00, CMD_READBACK, 16'h1234);
    `CHK("ro", 1'b1, cmd_err_o)
    op(1'b0, 1'b1, 5'h11, CMD_OV_FAULT, '0);
    `CHK("page", 1'b1, cmd_err_o)
    $display("register test done");
    op(1'b1, 1'b0, 5'h00, CMD_EXPONENT, '0);
    op(1'b1, 1'b0, 5'h00, CMD_TRIM, '0);
    op(1'b1, 1'b0, 5'h00, CMD_OV_FAULT, 16'h0800);
    op(1'b1, 1'b0, 5'h00, CMD_OV_HYST, 16'h0040);
    op(1'b1, 1'b0, 5'h00, CMD_OV_WARN, 16'h0700);
    op(1'b1, 1'b0, 5'h00, CMD_CHAN_CFG, 16'h0241);
    in_code_i[0] = 12'h801;
    `WT(se_ov_fault_o[0], 80)
    `CHK("filter", 1'b1, i > 20)
    in_code_i[0] = 12'h7F0;
    repeat (100) @(posedge clk_i);
    `CHK("hyst", 1'b1, se_ov_fault_o[0])
    `CHK("warn", 1'b1, lb_ov_warn_o[0])
    op(1'b0, 1'b1, 5'h00, CMD_READBACK, '0);
    `CHK("readback", 16'h07F0, rdata_o)
    in_code_i[0] = 12'h7A0;
    `WT(!se_ov_fault_o[0], 40)
    repeat (100) @(posedge clk_i);
    `CHK("split", 2'b10, {lb_ov_warn_o[0], se_ov_fault_o[0]})
    $display("fault test done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
